// File: ota_top.sv
// Option byte, trim store, calibration and serial number access logic.
// Functional notes
// - user options are program bytes 0 and 1.
// - page 0 erase wipes user option bytes.
// - factory trim in info page, never software writable.
// - working trims reload from factory after reset.
// - 32 trim bytes selected by index 00H-1FH.
// - value write updates selected working trim byte.
// - value read returns selected working trim byte.
// - trim indices reach info 20-3F only.
// - calibration bytes readable via program memory read.
// - four-byte serial number read from info page.
// - converter calibration 60H-7DH read/write, reset-proof.
// - ten modes: offset, gain high, gain low.
`timescale 1ns/1ps
module ota_top import ota_pkg::*; #(
   parameter int PAW = PM_AW
) (
   input  wire logic         clk,              // System clock, 100 MHz.
   input  wire logic         reset_n,          // Asynchronous reset, active low.
   input  wire logic         ce,               // Clock enable, freezes all state when low.
   input  wire logic         factory_wr,       // Factory programming strobe for the info page.
   input  wire logic [6:0]   factory_addr,     // Factory programming address.
   input  wire logic [7:0]   factory_wdata,    // Factory programming data.
   input  wire logic         pm_wr,            // Program memory byte program strobe.
   input  wire logic [PAW-1:0] pm_addr,        // Program memory byte address.
   input  wire logic [7:0]   pm_wdata,         // Program memory byte data.
   input  wire logic         pm_page0_erase,   // Erase of program memory page 0.
   output logic      [15:0]  user_opt,         // User option bytes, byte 1 high.
   input  wire logic         trim_idx_wr,      // Trim index register write.
   input  wire logic [7:0]   trim_idx_wdata,   // Trim index write data.
   input  wire logic         trim_val_wr,      // Trim value register write.
   input  wire logic [7:0]   trim_val_wdata,   // Trim value write data.
   input  wire logic         trim_val_rd,      // Trim value register read.
   output logic      [7:0]   trim_rdata,       // Trim value read data.
   output logic              trim_rvalid,      // Trim read data valid pulse.
   output logic      [4:0]   trim_idx,         // Current trim index.
   output logic              trim_busy,        // Working trims being reloaded.
   input  wire logic         pmr_rd,           // Program memory read instruction to info area.
   input  wire logic [6:0]   pmr_addr,         // Info page address of that read.
   output logic      [7:0]   pmr_rdata,        // Read data.
   output logic              pmr_valid,        // Read data valid pulse.
   input  wire logic         info_wr,          // Software write to the info page.
   input  wire logic [6:0]   info_waddr,       // Address of that write.
   input  wire logic [7:0]   info_wdata,       // Data of that write.
   input  wire logic         cal_rd,           // Converter calibration read.
   input  wire logic [3:0]   cal_mode,         // Converter mode, 0 to 9.
   input  wire logic [1:0]   cal_sel,          // 0 offset, 1 gain high, 2 gain low.
   output logic      [7:0]   cal_rdata,        // Calibration read data.
   output logic              cal_valid,        // Calibration data valid pulse.
   output logic      [31:0]  serial_num,       // Serial number, first byte highest.
   output logic              serial_valid      // Serial number captured.
);

   // ****************************************************
   // State
   // ****************************************************
   ota_state_t  st_r;
   ota_state_t  st_nxt;
   logic [5:0]  ld_cnt_r;
   logic        pend_r;
   logic [5:0]  pend_idx_r;
   logic [4:0]  trim_idx_r;
   logic        pmr_valid_r;
   logic        cal_valid_r;
   logic        trim_rvalid_r;
   logic [31:0] serial_r;
   logic        serial_valid_r;
   logic [15:0] user_opt_r;
   logic [7:0]  info_rdata;
   logic [7:0]  trim_mem_rdata;

   // ****************************************************
   // Decoding and selection
   // ****************************************************
   wire        seq_issue  = (st_r == ST_LOAD);
   wire        busy       = (st_r != ST_RUN) || pend_r;
   wire        pmr_go     = pmr_rd && !busy;
   wire        cal_ok     = (cal_mode < ADC_MODES) && (cal_sel < ADC_CAL_BYTES);
   wire        cal_go     = cal_rd && cal_ok && !busy && !pmr_rd;
   wire        trim_rd_go = trim_val_rd && !busy;
   wire        trim_wr_go = trim_val_wr && !busy;
   wire        ld_trim    = pend_r && (pend_idx_r < LOAD_SERIAL);
   wire        ld_serial  = pend_r && (pend_idx_r >= LOAD_SERIAL);
   wire [6:0]  seq_addr   = (ld_cnt_r < LOAD_SERIAL) ? TRIM_BASE + 7'(ld_cnt_r)
                                                     : SERIAL_BASE + 7'(ld_cnt_r - LOAD_SERIAL);
   wire [6:0]  cal_addr   = adc_cal_addr(cal_mode, cal_sel);
   wire        info_re    = seq_issue || pmr_go || cal_go;
   wire [6:0]  info_raddr = seq_issue ? seq_addr : (pmr_go ? pmr_addr : cal_addr);
   // Software may only touch the converter area; trim copies stay factory-only.
   wire        sw_info_go = info_wr && in_adc_range(info_waddr);
   wire        info_we    = factory_wr || sw_info_go;
   wire [6:0]  info_wa    = factory_wr ? factory_addr : info_waddr;
   wire [7:0]  info_wd    = factory_wr ? factory_wdata : info_wdata;
   wire        trim_we    = ld_trim || trim_wr_go;
   wire [4:0]  trim_wa    = ld_trim ? pend_idx_r[4:0] : trim_idx_r;
   wire [7:0]  trim_wd    = ld_trim ? info_rdata : trim_val_wdata;
   wire        pm_opt_hit = pm_wr && (pm_addr < PAW'(2));

   // ****************************************************
   // Memories
   // ****************************************************
   // Info page holding factory trims, serial number and converter calibration.
   ota_mem #(.W(8), .D(INFO_DEPTH), .AW(INFO_AW)) u_info (
      .clk   (clk),
      .ce    (ce),
      .we    (info_we),
      .waddr (info_wa),
      .wdata (info_wd),
      .re    (info_re),
      .raddr (info_raddr),
      .rdata (info_rdata)
   );

   // Working trim copies seen by the analog circuits and by software.
   ota_mem #(.W(8), .D(TRIM_N), .AW(TRIM_AW)) u_trim (
      .clk   (clk),
      .ce    (ce),
      .we    (trim_we),
      .waddr (trim_wa),
      .wdata (trim_wd),
      .re    (trim_rd_go),
      .raddr (trim_idx_r),
      .rdata (trim_mem_rdata)
   );

   // ****************************************************
   // Reload sequencer
   // ****************************************************
   // Every reset restarts the copy of factory trims into the working store.
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_LOAD: begin
            if (ld_cnt_r == LOAD_LAST) begin
               st_nxt = ST_RUN;
            end
         end
         default: st_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r       <= ST_LOAD;
         ld_cnt_r   <= 6'h00;
         pend_r     <= 1'b0;
         pend_idx_r <= 6'h00;
      end else if (ce) begin
         st_r       <= st_nxt;
         ld_cnt_r   <= seq_issue ? ld_cnt_r + 6'h01 : ld_cnt_r;
         pend_r     <= seq_issue;
         pend_idx_r <= ld_cnt_r;
      end
   end

   // Serial bytes arrive first byte first and shift in from the bottom.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_r       <= 32'h00000000;
         serial_valid_r <= 1'b0;
      end else if (ce && ld_serial) begin
         serial_r       <= {serial_r[23:0], info_rdata};
         serial_valid_r <= (pend_idx_r == LOAD_LAST);
      end
   end

   // ****************************************************
   // Software access
   // ****************************************************
   // Only the low five index bits are kept so nothing beyond the trim window is exposed.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trim_idx_r    <= TRIM_IDX_RST;
         pmr_valid_r   <= 1'b0;
         cal_valid_r   <= 1'b0;
         trim_rvalid_r <= 1'b0;
      end else if (ce) begin
         if (trim_idx_wr) begin
            trim_idx_r <= trim_idx_wdata[4:0];
         end
         pmr_valid_r   <= pmr_go;
         cal_valid_r   <= cal_go;
         trim_rvalid_r <= trim_rd_go;
      end
   end

   // Option bytes live in flash: reset leaves them, programming only clears bits.
   always_ff @(posedge clk) begin
      if (ce) begin
         if (pm_page0_erase) begin
            user_opt_r <= USER_OPT_ERASED;
         end else if (pm_opt_hit && pm_addr[0]) begin
            user_opt_r[15:8] <= user_opt_r[15:8] & pm_wdata;
         end else if (pm_opt_hit) begin
            user_opt_r[7:0] <= user_opt_r[7:0] & pm_wdata;
         end
      end
   end

   // Outputs.
   assign user_opt     = user_opt_r;
   assign trim_rdata   = trim_mem_rdata;
   assign trim_rvalid  = trim_rvalid_r;
   assign trim_idx     = trim_idx_r;
   assign trim_busy    = busy;
   assign pmr_rdata    = info_rdata;
   assign pmr_valid    = pmr_valid_r;
   assign cal_rdata    = info_rdata;
   assign cal_valid    = cal_valid_r;
   assign serial_num   = serial_r;
   assign serial_valid = serial_valid_r;

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   idx_wrap_a: assert property (ce && trim_idx_wr |=> trim_idx == $past(trim_idx_wdata[4:0]))
      else $error("Trim index did not keep the low five bits.");
   trim_rd_a: assert property (ce && trim_val_rd && !trim_busy |=> trim_rvalid)
      else $error("Trim read gave no valid pulse.");
   trim_wr_rd_a: assert property (ce && trim_wr_go ##1 ce && trim_rd_go && $stable(trim_idx_r)
                                  |=> trim_rdata == $past(trim_val_wdata, 2))
      else $error("Trim read did not return the value just written.");
   load_len_a: assert property ($fell(trim_busy) |-> $past(pend_idx_r) == LOAD_LAST)
      else $error("Reload ended before all bytes were copied.");
   load_window_a: assert property (seq_issue && ld_cnt_r < LOAD_SERIAL
                                   |-> info_raddr >= TRIM_BASE && info_raddr <= TRIM_LAST)
      else $error("Trim reload left the trim window.");
   info_guard_a: assert property (info_we && !factory_wr |-> in_adc_range(info_wa))
      else $error("Software wrote outside the converter area.");
   opt_erase_a: assert property (ce && pm_page0_erase |=> user_opt == USER_OPT_ERASED)
      else $error("Page 0 erase left option bytes set.");
   pmr_lat_a: assert property (ce && pmr_rd && !trim_busy |=> pmr_valid && !cal_valid)
      else $error("Info read gave no valid pulse.");
   cal_addr_a: assert property (cal_go && !seq_issue |-> info_raddr == cal_addr
                                && in_adc_range(info_raddr))
      else $error("Calibration read address out of area.");
   serial_done_a: assert property ($fell(trim_busy) |-> serial_valid)
      else $error("Serial number not captured by end of reload.");

   load_done_c:  cover property ($fell(trim_busy));
   trim_wr_rd_c: cover property (trim_wr_go ##1 trim_rd_go);
   cal_rd_c:     cover property (cal_go && cal_mode == 4'h9 && cal_sel == 2'h2);
   opt_prog_c:   cover property (pm_opt_hit ##1 pm_page0_erase);

endmodule

// File: ota_pkg.sv
// Constants and helpers shared by the option and trim access block.
package ota_pkg;

   // ****************************************************
   // Information page layout
   // ****************************************************
   localparam int         INFO_AW       = 7;
   localparam int         INFO_DEPTH    = 128;
   localparam logic [6:0] TRIM_BASE     = 7'h20;
   localparam logic [6:0] TRIM_LAST     = 7'h3f;
   localparam int         TRIM_N        = 32;
   localparam int         TRIM_AW       = 5;
   localparam logic [6:0] SERIAL_BASE   = 7'h40;
   localparam int         SERIAL_N      = 4;
   localparam logic [6:0] ADC_CAL_FIRST = 7'h60;
   localparam logic [6:0] ADC_CAL_LAST  = 7'h7d;
   localparam logic [3:0] ADC_MODES     = 4'ha;
   localparam logic [1:0] ADC_CAL_BYTES = 2'h3;

   // ****************************************************
   // Reset values and counts
   // ****************************************************
   localparam logic [5:0]  LOAD_LAST    = 6'h23;
   localparam logic [5:0]  LOAD_SERIAL  = 6'h20;
   localparam logic [15:0] USER_OPT_ERASED = 16'hffff;
   localparam logic [4:0]  TRIM_IDX_RST = 5'h00;
   localparam int          PM_AW        = 12;

   // Loader states.
   typedef enum logic [0:0] {
      ST_LOAD = 1'b0,
      ST_RUN  = 1'b1
   } ota_state_t;

   // Byte address of one converter calibration byte: sel 0 offset, 1 gain high, 2 gain low.
   function automatic logic [6:0] adc_cal_addr(input logic [3:0] mode, input logic [1:0] sel);
      logic [6:0] a;
      a = ADC_CAL_FIRST + 7'(mode) * 7'h03 + 7'(sel);
      return a;
   endfunction

   // True when an address lies in the writable converter calibration area.
   function automatic logic in_adc_range(input logic [6:0] a);
      logic r;
      r = (a >= ADC_CAL_FIRST) && (a <= ADC_CAL_LAST);
      return r;
   endfunction

endpackage

// File: ota_mem.sv
// Small synchronous byte memory with a registered read port.
`timescale 1ns/1ps
module ota_mem import ota_pkg::*; #(
   parameter int W  = 8,
   parameter int D  = 128,
   parameter int AW = 7
) (
   input  wire logic          clk,    // System clock.
   input  wire logic          ce,     // Clock enable, freezes the memory when low.
   input  wire logic          we,     // Write strobe.
   input  wire logic [AW-1:0] waddr,  // Write address.
   input  wire logic [W-1:0]  wdata,  // Write data.
   input  wire logic          re,     // Read strobe.
   input  wire logic [AW-1:0] raddr,  // Read address.
   output logic      [W-1:0]  rdata   // Registered read data.
);

   logic [W-1:0] mem [D];

   // Contents have no reset: nonvolatile and calibration data must outlive any reset.
   always_ff @(posedge clk) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
      if (ce && re) begin
         rdata <= mem[raddr];
      end
   end

endmodule

// File: ota_top_tb.sv
// Self-checking testbench for the option and trim access block.
`timescale 1ns/1ps
module ota_top_tb import ota_pkg::*;;
   logic        clk, reset_n, ce, factory_wr, pm_wr, pm_page0_erase, trim_idx_wr, trim_val_wr, trim_val_rd;
   logic        pmr_rd, info_wr, cal_rd, trim_rvalid, trim_busy, pmr_valid, cal_valid, serial_valid;
   logic [6:0]  factory_addr, pmr_addr, info_waddr;
   logic [7:0]  factory_wdata, pm_wdata, trim_idx_wdata, trim_val_wdata, info_wdata;
   logic [7:0]  trim_rdata, pmr_rdata, cal_rdata;
   logic [11:0] pm_addr;
   logic [3:0]  cal_mode;
   logic [1:0]  cal_sel;
   logic [4:0]  trim_idx;
   logic [15:0] user_opt;
   logic [31:0] serial_num;
   logic [7:0]  info_m [128];
   logic [7:0]  work_m [32];
   logic [7:0]  tq[$], pq[$], cq[$];
   int          fails, checks;
   int unsigned r;

   ota_top ota_top_i (.clk(clk), .reset_n(reset_n), .ce(ce), .factory_wr(factory_wr), .factory_addr(factory_addr),
      .factory_wdata(factory_wdata), .pm_wr(pm_wr), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
      .pm_page0_erase(pm_page0_erase), .user_opt(user_opt), .trim_idx_wr(trim_idx_wr),
      .trim_idx_wdata(trim_idx_wdata), .trim_val_wr(trim_val_wr), .trim_val_wdata(trim_val_wdata),
      .trim_val_rd(trim_val_rd), .trim_rdata(trim_rdata), .trim_rvalid(trim_rvalid), .trim_idx(trim_idx),
      .trim_busy(trim_busy), .pmr_rd(pmr_rd), .pmr_addr(pmr_addr), .pmr_rdata(pmr_rdata), .pmr_valid(pmr_valid),
      .info_wr(info_wr), .info_waddr(info_waddr), .info_wdata(info_wdata), .cal_rd(cal_rd), .cal_mode(cal_mode),
      .cal_sel(cal_sel), .cal_rdata(cal_rdata), .cal_valid(cal_valid), .serial_num(serial_num),
      .serial_valid(serial_valid));

   // ****************************************************
   // Checking and closing
   // ****************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ****************************************************
   // Drivers
   // ****************************************************
   // Reset, then wait a bounded time for the reload to finish; working trims follow the factory copy.
   task automatic do_reset(input int n);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (n) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 32; i++) work_m[i] = info_m[TRIM_BASE + 7'(i)];
      for (int i = 0; i < 60; i++) begin
         @(negedge clk);
         if (trim_busy === 1'b0) return;
      end
      fails++;
      complete_run();
   endtask

   // Strobes rise after one edge and fall at the edge that takes them.
   task automatic info_write(input bit fac, input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      {factory_wr, info_wr} <= {fac, !fac};
      {factory_addr, info_waddr, factory_wdata, info_wdata} <= {a, a, d, d};
      @(posedge clk);
      {factory_wr, info_wr} <= 2'b00;
      if (fac || (a >= 7'h60 && a <= 7'h7d)) info_m[a] = d;
   endtask

   task automatic trim_op(input int k, input logic [4:0] i, input logic [7:0] d);
      @(posedge clk);
      {trim_idx_wr, trim_val_wr, trim_val_rd} <= 3'b100 >> k;
      trim_idx_wdata <= {3'(r), i};
      trim_val_wdata <= d;
      @(posedge clk);
      {trim_idx_wr, trim_val_wr, trim_val_rd} <= 3'b000;
      if (k == 1) work_m[i] = d;
      if (k == 2) tq.push_back(work_m[i]);
      // Settle past the edge so callers see the index and data that it launched.
      @(negedge clk);
   endtask

   task automatic rd_info(input logic [6:0] a, input logic [3:0] m, input logic [1:0] s, input bit cal);
      @(posedge clk);
      {pmr_rd, cal_rd} <= {!cal, cal};
      {pmr_addr, cal_mode, cal_sel} <= {a, m, s};
      @(posedge clk);
      {pmr_rd, cal_rd} <= 2'b00;
      if (!cal) pq.push_back(info_m[a]);
      else if (m <= 4'h9 && s <= 2'h2) cq.push_back(info_m[7'h60 + 7'(m) * 7'h03 + 7'(s)]);
   endtask

   task automatic pm_op(input bit er, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      {pm_page0_erase, pm_wr, pm_addr, pm_wdata} <= {er, !er, a, d};
      @(posedge clk);
      {pm_page0_erase, pm_wr} <= 2'b00;
      @(negedge clk);
   endtask

   // ****************************************************
   // Clock and result monitor
   // ****************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Each valid pulse retires the oldest noted result; a pulse with nothing noted is a fault.
   always @(negedge clk) begin
      if (trim_rvalid === 1'b1) chk(trim_rdata, tq.size() ? tq.pop_front() : 8'hxx);
      if (pmr_valid === 1'b1) chk(pmr_rdata, pq.size() ? pq.pop_front() : 8'hxx);
      if (cal_valid === 1'b1) chk(cal_rdata, cq.size() ? cq.pop_front() : 8'hxx);
   end

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      {reset_n, factory_wr, pm_wr, pm_page0_erase, trim_idx_wr, trim_val_wr, trim_val_rd} = 7'h00;
      {pmr_rd, info_wr, cal_rd, factory_addr, pmr_addr, info_waddr, cal_mode, cal_sel} = '0;
      {factory_wdata, pm_wdata, trim_idx_wdata, trim_val_wdata, info_wdata, pm_addr} = '0;
      ce = 1'b1;
      r = $urandom(32'hdd16);
      do_reset(10);
      for (int a = 0; a < 128; a++) info_write(1'b1, 7'(a), 8'($urandom));
      do_reset(2);
      chk(serial_num, {info_m[SERIAL_BASE], info_m[SERIAL_BASE + 1], info_m[SERIAL_BASE + 2], info_m[SERIAL_BASE + 3]});
      chk(serial_valid, 32'h1);
      // Index writes carry random upper bits that must be dropped.
      for (int i = 0; i < 32; i++) begin
         r = $urandom;
         trim_op(0, 5'(i), 8'h00);
         chk(trim_idx, i);
         trim_op(2, 5'(i), 8'h00);
      end
      for (int i = 0; i < 32; i += 3) begin
         trim_op(0, 5'(i), 8'h00);
         trim_op(1, 5'(i), 8'($urandom));
         trim_op(2, 5'(i), 8'h00);
      end
      // Back-to-back write and read on index 30, then a write under a low clock enable that must not land.
      @(posedge clk);
      {trim_val_wr, trim_val_wdata} <= {1'b1, 8'hc3};
      @(posedge clk);
      {trim_val_wr, trim_val_rd} <= 2'b01;
      work_m[30] = 8'hc3;
      tq.push_back(8'hc3);
      @(posedge clk);
      trim_val_rd <= 1'b0;
      @(posedge clk);
      {ce, trim_val_wr, trim_val_wdata} <= {1'b0, 1'b1, 8'h3c};
      @(posedge clk);
      {ce, trim_val_wr} <= 2'b10;
      trim_op(2, 5'd30, 8'h00);
      for (int a = 8'h1e; a < 8'h42; a++) rd_info(7'(a), 4'h0, 2'h0, 1'b0);
      // Software writes reach only the converter area; the rest is silently kept.
      for (int a = 8'h5f; a < 8'h7f; a++) info_write(1'b0, 7'(a), 8'($urandom));
      info_write(1'b0, TRIM_BASE, 8'h5a);
      rd_info(TRIM_BASE, 4'h0, 2'h0, 1'b0);
      rd_info(7'h7e, 4'h0, 2'h0, 1'b0);
      for (int m = 0; m < 11; m++) begin
         for (int s = 0; s < 4; s++) rd_info(7'h00, 4'(m), 2'(s), 1'b1);
      end
      do_reset(2);
      for (int i = 0; i < 32; i += 3) begin
         trim_op(0, 5'(i), 8'h00);
         trim_op(2, 5'(i), 8'h00);
      end
      for (int m = 0; m < 10; m++) rd_info(7'h00, 4'(m), 2'(m % 3), 1'b1);
      // Option bytes live in program bytes 0 and 1 and erase to all ones.
      pm_op(1'b1, 12'h000, 8'h00);
      chk(user_opt, 16'hffff);
      pm_op(1'b0, 12'h000, 8'h3c);
      pm_op(1'b0, 12'h001, 8'ha5);
      pm_op(1'b0, 12'h002, 8'h00);
      chk(user_opt, 16'ha53c);
      pm_op(1'b1, 12'h000, 8'h00);
      chk(user_opt, 16'hffff);
      repeat (3) @(posedge clk);
      chk(tq.size() + pq.size() + cq.size(), 32'h0);
      complete_run();
   end
endmodule
